// ==== hw/ptc_defines.svh ====
// Purpose: constants for the terminal connect control register block
// Assumes: 9-bit register at serial address 0x04
// Notes:   width and reset value are shared by core and holding register
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

`define PTC_ADDR_TCC        4'h4
`define PTC_REG_W           9
`define PTC_RESET_VAL       9'h1FF
`define PTC_BIT_BCAST       8
`define PTC_POT1_LSB        4
`define PTC_POT0_LSB        0
`define PTC_OFS_SHDN_N      3
`define PTC_OFS_TERM_A      2
`define PTC_OFS_WIPER       1
`define PTC_OFS_TERM_B      0
`define PTC_NIB_W           4
`define PTC_NIB_RESET       4'hF

`endif

// ==== hw/ptc_pkg.sv ====
// Purpose: types for the terminal connect control register block
// Assumes: ptc_defines.svh holds all numeric constants
// Notes:   switch bundle is what the analog side consumes
package ptc_pkg;

	// one network's nibble of the register
	typedef struct packed {
		logic force_shutdown_n;
		logic term_a_connect;
		logic wiper_connect;
		logic term_b_connect;
	} ptc_pot_ctl_s;

	// analog switch drive for one network
	typedef struct packed {
		logic term_a_pin;
		logic wiper_pin;
		logic term_b_pin;
		logic wiper_to_b;
	} ptc_pot_sw_s;

	typedef enum logic [1:0] {
		PTC_IDLE    = 2'b00,
		PTC_PENDING = 2'b01,
		PTC_APPLY   = 2'b10
	} ptc_state_e;

endpackage : ptc_pkg

// ==== hw/ptc_hold_reg.sv ====
// Purpose: staging register for a value written mid-command
// Assumes: load is a single-cycle pulse
// Notes:   read data comes straight from the flop
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"

module ptc_hold_reg #(
	parameter int W = `PTC_REG_W
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_data,
	output logic      [W-1:0] o_data
);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_data <= W'(`PTC_RESET_VAL);
		end else if (i_load) begin
			o_data <= i_data;
		end
	end

endmodule : ptc_hold_reg
`default_nettype wire

// ==== hw/ptc_core.sv ====
// Operation
// - bit8 broadcast enable, nibbles pot1, pot0
// - apply written value after command completes
// - pot1 lock blocks pot1 nibble writes
// - pot0 lock blocks pot0 nibble writes
// - reset loads all nine bits one
// - broadcast enable gates general call acceptance
// - pot1 bits connect pins when one
// - pot0 bits connect pins when one
// - shutdown: A open, wiper tied B
// - shutdown ignores but keeps connect bits
// - shutdown never stalls serial commands
//
// Purpose: terminal connect control register and switch drive
// Assumes: command decoder gives address, write strobe, end-of-command
// Notes:   i_rst_n stands for power-on and brown-out reset
//          lock levels are sampled at the write edge, not at commit
//          switch outputs lag the register by one flop
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"

module ptc_core (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_n,
	input  wire logic [3:0]                 i_addr,
	input  wire logic                       i_wr,
	input  wire logic [`PTC_REG_W-1:0]      i_wdata,
	input  wire logic                       i_rd,
	input  wire logic                       i_cmd_done,
	input  wire logic                       i_gcall_seen,
	input  wire logic                       i_pot1_lock_status,
	input  wire logic                       i_pot0_lock_status,
	output logic      [`PTC_REG_W-1:0]      o_rdata,
	output logic                            o_rvalid,
	output logic                            o_gcall_accept,
	output logic                            o_broadcast_call_enable,
	output ptc_pkg::ptc_pot_sw_s            o_pot1_sw,
	output ptc_pkg::ptc_pot_sw_s            o_pot0_sw
);

	////////////////////////////////////////////////////////////////////
	// staging and merge

	logic [`PTC_REG_W-1:0] terminal_connect_control;
	logic [`PTC_REG_W-1:0] staged;
	logic [`PTC_REG_W-1:0] next_staged;
	logic                  stage_load;
	logic                  rd_hit;
	logic                  commit_now;
	ptc_pkg::ptc_state_e   state;

	// keep locked nibbles at the value already held
	function automatic logic [`PTC_REG_W-1:0] merge_locked(
		input logic [`PTC_REG_W-1:0] cur,
		input logic [`PTC_REG_W-1:0] wr,
		input logic                  lk1,
		input logic                  lk0
	);
		logic [`PTC_REG_W-1:0] r;
		r = wr;
		if (lk1) begin
			r[`PTC_POT1_LSB +: `PTC_NIB_W] = cur[`PTC_POT1_LSB +: `PTC_NIB_W];
		end
		if (lk0) begin
			r[`PTC_POT0_LSB +: `PTC_NIB_W] = cur[`PTC_POT0_LSB +: `PTC_NIB_W];
		end
		return r;
	endfunction : merge_locked

	////////////////////////////////////////////////////////////////////
	// address decode

	// one decode serves the write and read paths
	function automatic logic is_tcc_addr(input logic [3:0] a);
		return a == `PTC_ADDR_TCC;
	endfunction : is_tcc_addr

	// staged equals the register outside a command, and in the apply cycle
	// it is what the register is about to take, so locked nibbles merge on it
	assign stage_load  = i_wr && is_tcc_addr(i_addr);
	assign rd_hit      = i_rd && is_tcc_addr(i_addr);
	assign commit_now  = (state == ptc_pkg::PTC_APPLY);
	assign next_staged = merge_locked((state != ptc_pkg::PTC_IDLE) ? staged
		: terminal_connect_control, i_wdata, i_pot1_lock_status, i_pot0_lock_status);

	// the staging flop keeps mid-command writes off the live switches
	ptc_hold_reg #(.W(`PTC_REG_W)) ptc_hold_reg_i (
		.i_clk  (i_clk),
		.i_rst_n(i_rst_n),
		.i_load (stage_load),
		.i_data (next_staged),
		.o_data (staged)
	);

	////////////////////////////////////////////////////////////////////
	// commit sequencing
	// a done pulse with nothing pending is ignored; a write in the
	// apply cycle opens the next command

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state <= ptc_pkg::PTC_IDLE;
		end else begin
			case (state)
				ptc_pkg::PTC_IDLE: begin
					if (stage_load) begin
						state <= ptc_pkg::PTC_PENDING;
					end
				end
				ptc_pkg::PTC_PENDING: begin
					if (i_cmd_done) begin
						state <= ptc_pkg::PTC_APPLY;
					end
				end
				ptc_pkg::PTC_APPLY: begin
					state <= stage_load ? ptc_pkg::PTC_PENDING : ptc_pkg::PTC_IDLE;
				end
				default: begin
					state <= ptc_pkg::PTC_IDLE;
				end
			endcase
		end
	end

	// shutdown state never feeds back here, so commands keep running
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			terminal_connect_control <= `PTC_RESET_VAL;
		end else if (commit_now) begin
			terminal_connect_control <= staged;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read port

	// reads see only the committed value, never the staged one
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= rd_hit;
		end
	end

	// unmapped reads leave the last answer in place
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (rd_hit) begin
			o_rdata <= terminal_connect_control;
		end
	end

	////////////////////////////////////////////////////////////////////
	// broadcast call gating

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_broadcast_call_enable <= 1'b1;
		end else begin
			o_broadcast_call_enable <= terminal_connect_control[`PTC_BIT_BCAST];
		end
	end

	// gate uses the committed bit, so a pending write cannot open it early
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_gcall_accept <= 1'b0;
		end else begin
			o_gcall_accept <= i_gcall_seen
				&& terminal_connect_control[`PTC_BIT_BCAST];
		end
	end

	////////////////////////////////////////////////////////////////////
	// switch drive

	// shutdown overrides without touching stored connect bits
	function automatic ptc_pkg::ptc_pot_sw_s drive_switches(input logic [`PTC_NIB_W-1:0] nib);
		ptc_pkg::ptc_pot_sw_s s;
		ptc_pkg::ptc_pot_ctl_s c;
		c = nib;
		if (!c.force_shutdown_n) begin
			s.term_a_pin = 1'b0;
			s.wiper_pin  = 1'b1;
			s.term_b_pin = 1'b1;
			s.wiper_to_b = 1'b1;
		end else begin
			s.term_a_pin = c.term_a_connect;
			s.wiper_pin  = c.wiper_connect;
			s.term_b_pin = c.term_b_connect;
			s.wiper_to_b = 1'b0;
		end
		return s;
	endfunction : drive_switches

	// registered so the analog side never sees a decode glitch
	logic [`PTC_NIB_W-1:0] pot1_nib;
	logic [`PTC_NIB_W-1:0] pot0_nib;

	assign pot1_nib = terminal_connect_control[`PTC_POT1_LSB +: `PTC_NIB_W];
	assign pot0_nib = terminal_connect_control[`PTC_POT0_LSB +: `PTC_NIB_W];

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pot1_sw <= drive_switches(`PTC_NIB_RESET);
		end else begin
			o_pot1_sw <= drive_switches(pot1_nib);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pot0_sw <= drive_switches(`PTC_NIB_RESET);
		end else begin
			o_pot0_sw <= drive_switches(pot0_nib);
		end
	end

endmodule : ptc_core
`default_nettype wire

// ==== verification/ptc_core_sva.sv ====
// Purpose: port-level checker for ptc_core
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the core's ports
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"
module ptc_core_sva (
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	input wire logic [3:0]            i_addr,
	input wire logic                  i_wr,
	input wire logic [`PTC_REG_W-1:0] i_wdata,
	input wire logic                  i_rd,
	input wire logic                  i_cmd_done,
	input wire logic                  i_gcall_seen,
	input wire logic                  i_pot1_lock_status,
	input wire logic                  i_pot0_lock_status,
	input wire logic [`PTC_REG_W-1:0] o_rdata,
	input wire logic                  o_rvalid,
	input wire logic                  o_gcall_accept,
	input wire logic                  o_broadcast_call_enable,
	input wire ptc_pkg::ptc_pot_sw_s  o_pot1_sw,
	input wire ptc_pkg::ptc_pot_sw_s  o_pot0_sw
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic sel;
	assign sel = i_addr == `PTC_ADDR_TCC;
	////////////////////////////////////////////////////////////////////////
	sequence s_commit;
		i_wr && sel ##1 i_cmd_done && !i_wr;
	endsequence
	sequence s_lk(logic lk);
		!i_wr && !i_cmd_done ##1 i_wr && sel && lk ##1 i_cmd_done && !i_wr;
	endsequence
	a_rd_answer: assert property (i_rd && sel |=> o_rvalid)
		else $error("read gave no valid");
	a_rd_only: assert property (o_rvalid |-> $past(i_rd && sel))
		else $error("valid without read");
	a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data moved");
	a_sw_wait: assert property (!$past(i_cmd_done, 3) |-> $stable({o_pot1_sw, o_pot0_sw}))
		else $error("switches moved before commit");
	a_shdn_pot1: assert property (o_pot1_sw.wiper_to_b |-> o_pot1_sw == 4'h7)
		else $error("pot1 shutdown shape");
	a_shdn_pot0: assert property (o_pot0_sw.wiper_to_b |-> o_pot0_sw == 4'h7)
		else $error("pot0 shutdown shape");
	a_reset_load: assert property ($rose(i_rst_n) |-> {o_pot1_sw, o_pot0_sw} == 8'hEE)
		else $error("switches not reset");
	a_gcall_gate: assert property (o_gcall_accept == ($past(i_gcall_seen) && o_broadcast_call_enable))
		else $error("general call gating");
	a_bcast_apply: assert property (s_commit |-> ##3 o_broadcast_call_enable == $past(i_wdata[8], 4))
		else $error("enable not applied");
	a_lock1_keep: assert property (s_lk(i_pot1_lock_status) |-> ##3 $stable(o_pot1_sw))
		else $error("pot1 lock broken");
	a_lock0_keep: assert property (s_lk(i_pot0_lock_status) |-> ##3 $stable(o_pot0_sw))
		else $error("pot0 lock broken");
endmodule : ptc_core_sva
bind ptc_core ptc_core_sva ptc_core_sva_i (.*);
`default_nettype wire

// ==== verification/ptc_host_model.sv ====
// Purpose: serial host that writes and reads the register
// Assumes: one command per call
// Notes:   idle data shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"
module ptc_host_model (
	input  wire logic                  i_clk,
	output logic      [3:0]            o_addr,
	output logic                       o_wr,
	output logic      [`PTC_REG_W-1:0] o_wdata,
	output logic                       o_rd,
	output logic                       o_cmd_done,
	input  wire logic [`PTC_REG_W-1:0] i_rdata,
	input  wire logic                  i_rvalid
);
	initial begin
		{o_addr, o_wr, o_wdata, o_rd, o_cmd_done} = '0;
	end
	// caller rewrites the register after every reset
	task automatic cmd_write(input logic [`PTC_REG_W-1:0] d, input int gap);
		@(negedge i_clk);
		o_addr = `PTC_ADDR_TCC;
		o_wr = 1'b1;
		o_wdata = d;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_addr = 4'h0;
		o_wdata = ~d;
		repeat (gap) @(negedge i_clk);
		o_cmd_done = 1'b1;
		@(negedge i_clk);
		o_cmd_done = 1'b0;
	endtask : cmd_write
	task automatic read_reg(input logic [3:0] a, output logic [`PTC_REG_W-1:0] q, output logic v);
		@(negedge i_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk);
		o_rd = 1'b0;
		o_addr = 4'h0;
		q = i_rdata;
		v = i_rvalid;
	endtask : read_reg
endmodule : ptc_host_model
`default_nettype wire

// ==== verification/ptc_core_tb.sv ====
// Purpose: self-checking bench for ptc_core
// Assumes: host model drives the command side
// Notes:   locks and general call driven here
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"
module ptc_core_tb;
	logic                 clk = 0, rst_n = 0, gcall = 0, lk1 = 0, lk0 = 0;
	logic [3:0]           addr;
	logic                 wr, rd, done, rvalid, acc, en, v;
	logic [8:0]           wdata, rdata, q, exp_sw;
	ptc_pkg::ptc_pot_sw_s sw1, sw0;
	int                   err_total = 0, checks_done = 0, cyc = 0;
	initial forever #4 clk = ~clk;
	ptc_host_model host_i (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
		.o_cmd_done(done), .i_rdata(rdata), .i_rvalid(rvalid));
	ptc_core ptc_core_i (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr),
		.i_wdata(wdata), .i_rd(rd), .i_cmd_done(done), .i_gcall_seen(gcall),
		.i_pot1_lock_status(lk1), .i_pot0_lock_status(lk0), .o_rdata(rdata),
		.o_rvalid(rvalid), .o_gcall_accept(acc), .o_broadcast_call_enable(en),
		.o_pot1_sw(sw1), .o_pot0_sw(sw0));
	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (err_total == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	// hang guard: whole run needs under a hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			final_report();
		end
	end
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
		checks_done++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask : chk
	task automatic t_reset();
		host_i.read_reg(`PTC_ADDR_TCC, q, v);
		chk("rvalid", 9'h001, {8'h00, v});
		chk("rdata_rst", 9'h1FF, q);
		chk("sw_rst", 9'h0EE, {1'b0, sw1, sw0});
		exp_sw = 9'h0EE;
		host_i.read_reg(4'h3, q, v);
		chk("rvalid_unmapped", 9'h000, {8'h00, v});
	endtask : t_reset
	// gap 0 puts done right after the write, as the checker's sequences expect
	task automatic t_cmd(input logic [8:0] d, e1, e0, er, input int g);
		host_i.cmd_write(d, g);
		chk("sw_early", exp_sw, {1'b0, sw1, sw0});
		repeat (3) @(negedge clk);
		chk("sw1", e1, {5'h00, sw1});
		chk("sw0", e0, {5'h00, sw0});
		exp_sw = {1'b0, e1[3:0], e0[3:0]};
		host_i.read_reg(`PTC_ADDR_TCC, q, v);
		chk("rdata", er, q);
	endtask : t_cmd
	task automatic t_gcall(input logic e);
		@(negedge clk);
		gcall = 1'b1;
		@(negedge clk);
		gcall = 1'b0;
		chk("gcall_accept", {8'h00, e}, {8'h00, acc});
		chk("bcast_enable", {8'h00, e}, {8'h00, en});
	endtask : t_gcall
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_cmd(9'h0A5, 9'h004, 9'h007, 9'h0A5, 2);
		t_gcall(1'b0);
		t_cmd(9'h15A, 9'h007, 9'h004, 9'h15A, 2);
		t_gcall(1'b1);
		lk1 = 1'b1;
		t_cmd(9'h0FF, 9'h007, 9'h00E, 9'h05F, 0);
		lk1 = 1'b0;
		lk0 = 1'b1;
		t_cmd(9'h130, 9'h007, 9'h00E, 9'h13F, 0);
		lk0 = 1'b0;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_cmd(9'h1A0, 9'h004, 9'h007, 9'h1A0, 2);
		final_report();
	end
endmodule : ptc_core_tb
`default_nettype wire
